// ---- dv/dpio_pins_model.sv ----
// External switches and signals on one 8-bit port
`timescale 1ns/1ps
module dpio_pins_model #(parameter int unsigned W = 8) (
  input wire logic clk_sys_i,
  input wire logic [W-1:0] drive_i,
  input wire logic [W-1:0] oe_n_i,
  input wire logic [W-1:0] pull_i,
  input wire logic [W-1:0] sw_val_i,
  input wire logic [W-1:0] sw_on_i,
  output logic [W-1:0] level_o
);
  // Starts low so a floating pin toggles rather than staying unknown
  logic [W-1:0] flt = '0;
  // Floating pin wanders, so a missing pull-up never reads steady
  always_ff @(posedge clk_sys_i) begin
    flt <= ~level_o;
  end
  // Device drive wins, then the switch, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n_i[i])
        level_o[i] = drive_i[i];
      else if (sw_on_i[i])
        level_o[i] = sw_val_i[i];
      else if (pull_i[i])
        level_o[i] = 1'b1;
      else
        level_o[i] = flt[i];
    end
  end
endmodule

// ---- dv/dpio_top_monitor.sv ----
// Checker of bus, pad and wake timing at the dual IO block ports
`timescale 1ns/1ps
module dpio_top_monitor #(parameter int unsigned W = 8) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [W-1:0] port_a_pad_i,
  input wire logic [W-1:0] port_a_pad_o,
  input wire logic [W-1:0] port_a_pad_oe_n_o,
  input wire logic [W-1:0] port_a_pull_o,
  input wire logic [W-1:0] port_b_pad_i,
  input wire logic [W-1:0] port_b_pad_oe_n_o,
  input wire logic [W-1:0] port_b_pull_o,
  input wire logic irq_o,
  input wire logic sys_stopped_o,
  input wire logic wake_o,
  input wire logic hw_reset_req_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Read stalls exactly one cycle
  sequence s_rd_answer;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  // Wake pulse lasts one cycle, stop flag falls with it
  sequence s_wake_end;
    wake_o && !sys_stopped_o ##1 !wake_o;
  endsequence
  property p_rd_wait;
    avs_read_i && !$past(avs_read_i) |-> s_rd_answer;
  endproperty
  property p_wr_nowait;
    avs_write_i |-> !avs_waitrequest_o;
  endproperty
  property p_a5_od;
    port_a_pad_o[5] == 1'b0 && port_a_pull_o[5] == 1'b0;
  endproperty
  property p_pull_in;
    ((port_a_pull_o & ~port_a_pad_oe_n_o) | (port_b_pull_o & ~port_b_pad_oe_n_o)) == '0;
  endproperty
  // Irq may only rise after a pin edge or a register write; flag then level add two edges
  property p_irq_src;
    $rose(irq_o) |-> $past(avs_write_i, 2)
      || ($past(port_a_pad_i[0], 2) != $past(port_a_pad_i[0], 3))
      || ($past(port_b_pad_i[0], 2) != $past(port_b_pad_i[0], 3));
  endproperty
  property p_hwrst;
    hw_reset_req_o |-> !port_a_pad_i[5] && port_a_pad_oe_n_o[5];
  endproperty
  property p_wake_pulse;
    $rose(wake_o) |-> s_wake_end;
  endproperty
  property p_wake_held;
    wake_o |-> $past(sys_stopped_o, 128);
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read not answered after one wait cycle");
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  a_a5_od: assert property (p_a5_od)
    else $error("port A bit5 drives or pulls high");
  a_pull_in: assert property (p_pull_in)
    else $error("pull-up on a driven pin");
  a_irq_src: assert property (p_irq_src)
    else $error("irq rose without cause");
  a_hwrst: assert property (p_hwrst)
    else $error("reset request without low input");
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse malformed");
  a_wake_held: assert property (p_wake_held)
    else $error("wake before 128 stopped cycles");
endmodule
bind dpio_top dpio_top_monitor #(.W(W)) mon_u (.clk_sys_i, .arst_n_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .port_a_pad_i, .port_a_pad_o, .port_a_pad_oe_n_o, .port_a_pull_o,
  .port_b_pad_i, .port_b_pad_oe_n_o, .port_b_pull_o, .irq_o, .sys_stopped_o, .wake_o,
  .hw_reset_req_o);

// ---- dv/dual_port_io_wakeup_interrupt_bench.sv ----
// Self-checking bench for the dual 8-bit IO ports
`timescale 1ns/1ps
module dual_port_io_wakeup_interrupt_bench;
  import dpio_pkg::*;
  logic clk_sys_i;
  logic arst_n_i;
  logic [ADDR_W-1:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic [3:0] be;
  logic wreq;
  logic [7:0] a_in, a_out, a_oen, a_pul, a_sw, a_on;
  logic [7:0] b_in, b_out, b_oen, b_pul, b_sw, b_on;
  logic irq, stopped, wake, hwr;
  int fail_count;
  int num_checks;
  dpio_top dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .port_a_pad_i(a_in), .port_a_pad_o(a_out), .port_a_pad_oe_n_o(a_oen),
    .port_a_pull_o(a_pul), .port_b_pad_i(b_in), .port_b_pad_o(b_out),
    .port_b_pad_oe_n_o(b_oen), .port_b_pull_o(b_pul), .irq_o(irq),
    .sys_stopped_o(stopped), .wake_o(wake), .hw_reset_req_o(hwr));
  dpio_pins_model pa_u (.clk_sys_i(clk_sys_i), .drive_i(a_out), .oe_n_i(a_oen),
    .pull_i(a_pul), .sw_val_i(a_sw), .sw_on_i(a_on), .level_o(a_in));
  dpio_pins_model pb_u (.clk_sys_i(clk_sys_i), .drive_i(b_out), .oe_n_i(b_oen),
    .pull_i(b_pul), .sw_val_i(b_sw), .sw_on_i(b_on), .level_o(b_in));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus request held until waitrequest is seen low at an edge
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wd <= {24'h0, d};
    wr <= 1'b1;
    do @(posedge clk_sys_i); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    adr <= a;
    rd <= 1'b1;
    do @(posedge clk_sys_i); while (wreq !== 1'b0);
    rd <= 1'b0;
    chk(nm, {24'h0, rdat[7:0]}, {24'h0, e});
  endtask
  task automatic t_regs();
    rd_chk("a_wake_en", OFS_A_WAKE_EN, RST_WAKE_EN);
    rd_chk("b_wake_en", OFS_B_WAKE_EN, RST_WAKE_EN);
    rd_chk("a_dir", OFS_A_DIR, RST_PORT_BYTE);
    bus_wr(6'h3c, 8'h5a);
    rd_chk("unmapped", 6'h3c, 8'h00);
    bus_wr(OFS_A_WAKE_EN, 8'h3c);
    rd_chk("a_wake_rw", OFS_A_WAKE_EN, 8'h3c);
    $display("test regs done");
  endtask
  // Mixed directions, pull-ups and the open-drain pin
  task automatic t_dir();
    bus_wr(OFS_A_DIR, 8'hf0);
    bus_wr(OFS_A_DATA, 8'hff);
    bus_wr(OFS_A_PULL, 8'hff);
    a_on <= 8'hfc;
    bus_wr(OFS_B_DIR, 8'h0f);
    bus_wr(OFS_B_DATA, 8'h05);
    bus_wr(OFS_B_PULL, 8'hff);
    b_sw <= 8'ha0;
    @(posedge clk_sys_i);
    chk("a_oe_n", a_oen, 8'h2f);
    chk("a_drive", a_out & ~a_oen, 8'hd0);
    chk("a_pull", a_pul, 8'h0f);
    chk("b_oe_n", b_oen, 8'hf0);
    chk("b_drive", b_out & ~b_oen, 8'h05);
    chk("b_pull", b_pul, 8'hf0);
    rd_chk("a_pins", OFS_A_DATA, 8'hf3);
    rd_chk("b_pins", OFS_B_DATA, 8'ha5);
    bus_wr(OFS_A_DATA, 8'h00);
    @(posedge clk_sys_i);
    chk("a5_sink", {a_oen[5], a_out[5]}, 2'b00);
    bus_wr(OFS_A_DIR, 8'h00);
    bus_wr(OFS_B_DIR, 8'h00);
    a_on <= 8'hff;
    b_sw <= 8'h00;
    $display("test dir done");
  endtask
  // Both edges of both lines, then one masked edge
  task automatic t_irq();
    logic [7:0] m;
    logic l;
    bus_wr(OFS_IRQ_STAT, 8'h03);
    for (int k = 0; k < 5; k++) begin
      l = (k == 2 || k == 3);
      m = (k == 4) ? 8'h00 : (l ? 8'h02 : 8'h01);
      bus_wr(OFS_IRQ_MASK, m);
      if (l)
        b_sw[0] <= ~b_sw[0];
      else
        a_sw[0] <= ~a_sw[0];
      repeat (3) @(posedge clk_sys_i);
      chk("irq_level", irq, |m);
      rd_chk("irq_stat", OFS_IRQ_STAT, l ? 8'h02 : 8'h01);
      bus_wr(OFS_IRQ_STAT, 8'h03);
      repeat (2) @(posedge clk_sys_i);
      chk("irq_clear", irq, 1'b0);
    end
    $display("test irq done");
  endtask
  // Disabled pin must not wake, enabled pin wakes after the fixed delay
  task automatic t_wake();
    int n;
    bus_wr(OFS_A_WAKE_EN, 8'h3f);
    bus_wr(OFS_B_WAKE_EN, 8'hfe);
    bus_wr(OFS_WAKE_STAT, 8'h03);
    for (int k = 0; k < 2; k++) begin
      bus_wr(OFS_CTRL, 8'h01);
      if (k == 0)
        a_sw[7] <= ~a_sw[7];
      else
        b_sw[0] <= ~b_sw[0];
      repeat (140) @(posedge clk_sys_i);
      chk("no_wake", {wake, stopped}, 2'b01);
      if (k == 0)
        a_sw[1] <= ~a_sw[1];
      else
        b_sw[3] <= ~b_sw[3];
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (wake !== 1'b1);
      chk("wake_delay", n >= FAST_WAKE_CYC && n <= FAST_WAKE_CYC + 3, 1);
      chk("resumed", stopped, 1'b0);
      rd_chk("wake_stat", OFS_WAKE_STAT, (k == 0) ? 8'h01 : 8'h02);
      bus_wr(OFS_WAKE_STAT, 8'h03);
    end
    $display("test wake done");
  endtask
  task automatic t_hwrst();
    bus_wr(OFS_CTRL, 8'h02);
    @(posedge clk_sys_i);
    chk("rst_req", hwr, 1'b1);
    rd_chk("rst_pin", OFS_A_DATA, a_sw | 8'h20);
    a_sw[5] <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("rst_idle", hwr, 1'b0);
    bus_wr(OFS_CTRL, 8'h00);
    $display("test hwrst done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // Main sequence; switches all closed to low at start
  initial begin
    arst_n_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wd = '0;
    be = 4'hf;
    a_sw = 8'h00;
    b_sw = 8'h00;
    a_on = 8'hff;
    b_on = 8'hff;
    fail_count = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_dir();
    t_irq();
    t_wake();
    t_hwrst();
    stop_test();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    $display("FAIL watchdog expected done seen hang");
    stop_test();
  end
endmodule

// ---- logic/dpio_pkg.sv ----
// Package: register map, field positions, reset values and timing for the dual port IO block
//
// Overview of operation
// [RQ1] Pins selectable input/output, switchable pull-up
// [RQ2] Port A toggle wakes, gated by enable
// [RQ3] Port B toggle wakes, gated by enable
// [RQ4] Port A bit0 both edges raise interrupt
// [RQ5] Port B bit0 both edges raise interrupt
// [RQ6] Port A bit5 open-drain only, no pull-up
// [RQ7] Crystal use needs software clearing enable bits
// [RQ8] Fast wake resumes after 128 clock periods
// [RQ9] Bit5 reset mode: low level resets controller
package dpio_pkg;
  localparam int unsigned ADDR_W = 6;
  // Register byte offsets
  localparam logic [5:0] OFS_A_DATA = 6'h00;
  localparam logic [5:0] OFS_A_DIR = 6'h04;
  localparam logic [5:0] OFS_A_PULL = 6'h08;
  localparam logic [5:0] OFS_A_WAKE_EN = 6'h0c;
  localparam logic [5:0] OFS_A_PIN = 6'h10;
  localparam logic [5:0] OFS_B_DATA = 6'h14;
  localparam logic [5:0] OFS_B_DIR = 6'h18;
  localparam logic [5:0] OFS_B_PULL = 6'h1c;
  localparam logic [5:0] OFS_B_WAKE_EN = 6'h20;
  localparam logic [5:0] OFS_B_PIN = 6'h24;
  localparam logic [5:0] OFS_CTRL = 6'h28;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h2c;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h30;
  localparam logic [5:0] OFS_WAKE_STAT = 6'h34;
  // Reset values
  localparam logic [7:0] RST_PORT_BYTE = 8'h00;
  localparam logic [7:0] RST_WAKE_EN = 8'hff;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // Field positions
  localparam int unsigned BIT_OD = 5;
  localparam int unsigned CTRL_STOP = 0;
  localparam int unsigned CTRL_RST_MODE = 1;
  localparam int unsigned IRQ_LINE_ZERO = 0;
  localparam int unsigned IRQ_LINE_ONE = 1;
  // Fast wake timing in system clock periods
  localparam int unsigned FAST_WAKE_TSYS = 128;
  localparam int unsigned FAST_WAKE_CYC = FAST_WAKE_TSYS;
  localparam int unsigned WAKE_CNT_W = 8;
  // Power sequencer states: running, stopped, resume delay
  typedef enum logic [1:0] {
    DPIO_RUN = 2'b00,
    DPIO_STOP = 2'b01,
    DPIO_WAKE = 2'b10
  } dpio_pwr_t;
endpackage

// ---- logic/dpio_port_if.sv ----
// Interface: one port's configuration and pin-side signals between top and port slice
`timescale 1ns/1ps
interface dpio_port_if #(parameter int unsigned W = 8);
  logic [W-1:0] out_val;
  logic [W-1:0] dir_out;
  logic [W-1:0] pull_en;
  logic [W-1:0] wake_en;
  logic [W-1:0] pad_in;
  logic [W-1:0] pad_o;
  logic [W-1:0] pad_oe_n;
  logic [W-1:0] pull_on;
  logic [W-1:0] pin_val;
  logic [W-1:0] toggle;
  modport top (output out_val, dir_out, pull_en, wake_en, pad_in,
               input pad_o, pad_oe_n, pull_on, pin_val, toggle);
  modport slice (input out_val, dir_out, pull_en, wake_en, pad_in,
                 output pad_o, pad_oe_n, pull_on, pin_val, toggle);
endinterface

// ---- logic/dpio_port_slice.sv ----
// Module: one 8-bit port, pad drive, pull-up, input capture and gated toggle detect
`timescale 1ns/1ps
module dpio_port_slice #(
  parameter int unsigned W = 8,
  parameter logic [7:0] OD_MASK = 8'h00
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  dpio_port_if.slice p
);
  import dpio_pkg::*;
  logic [W-1:0] pin_q;

  // Open-drain bits only ever drive low; push-pull bits drive the data value
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (OD_MASK[i]) begin
        p.pad_o[i] = 1'b0; // RQ6
        p.pad_oe_n[i] = ~(p.dir_out[i] & ~p.out_val[i]); // RQ6
        p.pull_on[i] = 1'b0; // RQ6
      end else begin
        p.pad_o[i] = p.out_val[i]; // RQ1
        p.pad_oe_n[i] = ~p.dir_out[i]; // RQ1
        p.pull_on[i] = p.pull_en[i] & ~p.dir_out[i]; // RQ1
      end
    end
  end

  // Registered pin sample for reads and edge detection
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_q <= '0;
    end else if (ce_i) begin
      pin_q <= p.pad_in;
    end
  end

  assign p.pin_val = pin_q;
  // Toggle gated per pin by the wake enable so disabled pins never leak events
  assign p.toggle = (pin_q ^ p.pad_in) & p.wake_en; // RQ2 RQ3
endmodule

// ---- logic/dpio_top.sv ----
// Module: dual 8-bit GPIO ports with wake-up, two edge interrupts, Avalon-MM slave
`timescale 1ns/1ps
module dpio_top #(
  parameter int unsigned W = 8
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [dpio_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [W-1:0] port_a_pad_i,
  output logic [W-1:0] port_a_pad_o,
  output logic [W-1:0] port_a_pad_oe_n_o,
  output logic [W-1:0] port_a_pull_o,
  input wire logic [W-1:0] port_b_pad_i,
  output logic [W-1:0] port_b_pad_o,
  output logic [W-1:0] port_b_pad_oe_n_o,
  output logic [W-1:0] port_b_pull_o,
  output logic irq_o,
  output logic sys_stopped_o,
  output logic wake_o,
  output logic hw_reset_req_o
);
  import dpio_pkg::*;

  logic [W-1:0] a_data, a_dir, a_pull, a_wake_en;
  logic [W-1:0] b_data, b_dir, b_pull, b_wake_en;
  logic [1:0] ctrl;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] wake_stat;
  logic rd_pend;
  logic [31:0] rd_data;
  logic wr_go;
  logic rd_go;
  logic [W-1:0] a_data_rd;
  logic edge_zero;
  logic edge_one;
  logic any_wake;
  logic stop_req;
  dpio_pwr_t pwr_state;
  dpio_pwr_t next_pwr_state;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic [W-1:0] a_pad_in_eff;
  // Decoded bus strobe, read decode and flag set terms
  logic [W-1:0] b_data_rd;
  logic [31:0] next_rd_data;
  logic wr_lane0;
  logic [1:0] irq_set;
  logic [1:0] wake_set;

  dpio_port_if #(.W(W)) pa ();
  dpio_port_if #(.W(W)) pb ();

  // Port A carries the open-drain bit; port B is all push-pull
  dpio_port_slice #(.W(W), .OD_MASK(8'h20)) u_port_a (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .p(pa)
  );
  dpio_port_slice #(.W(W), .OD_MASK(8'h00)) u_port_b (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .p(pb)
  );

  // In reset mode bit 5 is masked to high so it never reads as data nor wakes
  always_comb begin
    a_pad_in_eff = port_a_pad_i;
    if (ctrl[CTRL_RST_MODE]) begin
      a_pad_in_eff[BIT_OD] = 1'b1; // RQ9
    end
  end

  // Port A configuration into its slice, bit 5 released in reset mode
  assign pa.out_val = a_data;
  assign pa.dir_out = ctrl[CTRL_RST_MODE] ? (a_dir & ~(8'h01 << BIT_OD)) : a_dir; // RQ9
  assign pa.pull_en = a_pull;
  assign pa.wake_en = a_wake_en; // RQ2
  assign pa.pad_in = a_pad_in_eff;
  // Port B configuration into its slice
  assign pb.out_val = b_data;
  assign pb.dir_out = b_dir;
  assign pb.pull_en = b_pull;
  assign pb.wake_en = b_wake_en; // RQ3
  assign pb.pad_in = port_b_pad_i;

  // Pad-side outputs come straight from the slices
  assign port_a_pad_o = pa.pad_o;
  assign port_a_pad_oe_n_o = pa.pad_oe_n;
  assign port_a_pull_o = pa.pull_on;
  assign port_b_pad_o = pb.pad_o;
  assign port_b_pad_oe_n_o = pb.pad_oe_n;
  assign port_b_pull_o = pb.pull_on;

  // Active-low level on bit 5 resets the controller while reset mode is on
  assign hw_reset_req_o = ctrl[CTRL_RST_MODE] & ~port_a_pad_i[BIT_OD]; // RQ9

  // Interrupt edges are taken on both directions, independent of wake enable
  assign edge_zero = pa.pin_val[0] ^ a_pad_in_eff[0]; // RQ4
  assign edge_one = pb.pin_val[0] ^ port_b_pad_i[0]; // RQ5
  assign irq_set = {edge_one, edge_zero};
  assign any_wake = |pa.toggle | |pb.toggle; // RQ2 RQ3
  // Wake cause per port, bit 0 port A and bit 1 port B
  assign wake_set = {|pb.toggle, |pa.toggle};

  // Bus strobes: writes take effect at once, reads answer one cycle later
  assign wr_go = avs_write_i & ~avs_read_i;
  assign rd_go = avs_read_i & ~avs_write_i & ~rd_pend;
  // Read with write is refused without a stall, else the master would hang
  assign avs_waitrequest_o = avs_read_i & ~avs_write_i & ~rd_pend;
  assign avs_readdata_o = rd_data;
  assign wr_lane0 = wr_go & avs_byteenable_i[0];
  assign stop_req = wr_lane0 & (avs_address_i == OFS_CTRL)
                    & avs_writedata_i[CTRL_STOP];

  // Read pending flag so each read answers after exactly one wait cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_pend <= 1'b0;
    end else if (ce_i) begin
      rd_pend <= rd_go;
    end
  end

  // Port A data read returns output latch for pins with direction set, pin level otherwise
  assign a_data_rd = (a_dir & a_data) | (~a_dir & pa.pin_val);
  // Port B data read follows the same rule
  assign b_data_rd = (b_dir & b_data) | (~b_dir & pb.pin_val);

  // Read data decode, unmapped offsets read as zero
  always_comb begin
    next_rd_data = '0;
    if (avs_address_i == OFS_A_DATA) begin
      next_rd_data = {24'h000000, a_data_rd};
    end else if (avs_address_i == OFS_A_DIR) begin
      next_rd_data = {24'h000000, a_dir};
    end else if (avs_address_i == OFS_A_PULL) begin
      next_rd_data = {24'h000000, a_pull};
    end else if (avs_address_i == OFS_A_WAKE_EN) begin
      next_rd_data = {24'h000000, a_wake_en};
    end else if (avs_address_i == OFS_A_PIN) begin
      next_rd_data = {24'h000000, pa.pin_val};
    end else if (avs_address_i == OFS_B_DATA) begin
      next_rd_data = {24'h000000, b_data_rd};
    end else if (avs_address_i == OFS_B_DIR) begin
      next_rd_data = {24'h000000, b_dir};
    end else if (avs_address_i == OFS_B_PULL) begin
      next_rd_data = {24'h000000, b_pull};
    end else if (avs_address_i == OFS_B_WAKE_EN) begin
      next_rd_data = {24'h000000, b_wake_en};
    end else if (avs_address_i == OFS_B_PIN) begin
      next_rd_data = {24'h000000, pb.pin_val};
    end else if (avs_address_i == OFS_CTRL) begin
      next_rd_data = {30'h0, ctrl};
    end else if (avs_address_i == OFS_IRQ_STAT) begin
      next_rd_data = {30'h0, irq_stat};
    end else if (avs_address_i == OFS_IRQ_MASK) begin
      next_rd_data = {30'h0, irq_mask};
    end else if (avs_address_i == OFS_WAKE_STAT) begin
      next_rd_data = {30'h0, wake_stat};
    end
  end

  // Read data register, stands until the next accepted read
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data <= '0;
    end else if (ce_i && rd_go) begin
      rd_data <= next_rd_data;
    end
  end

  // Port A configuration registers, byte lane 0 only
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_data <= RST_PORT_BYTE;
      a_dir <= RST_PORT_BYTE;
      a_pull <= RST_PORT_BYTE;
      a_wake_en <= RST_WAKE_EN;
    end else if (ce_i && wr_lane0) begin
      if (avs_address_i == OFS_A_DATA) begin
        a_data <= avs_writedata_i[7:0]; // RQ1
      end else if (avs_address_i == OFS_A_DIR) begin
        a_dir <= avs_writedata_i[7:0]; // RQ1
      end else if (avs_address_i == OFS_A_PULL) begin
        a_pull <= avs_writedata_i[7:0] & ~(8'h01 << BIT_OD); // RQ6
      end else if (avs_address_i == OFS_A_WAKE_EN) begin
        // Crystal users clear bits 7 and 6 here
        a_wake_en <= avs_writedata_i[7:0]; // RQ7
      end
    end
  end

  // Port B configuration registers, all push-pull so no bit is forced
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      b_data <= RST_PORT_BYTE;
      b_dir <= RST_PORT_BYTE;
      b_pull <= RST_PORT_BYTE;
      b_wake_en <= RST_WAKE_EN;
    end else if (ce_i && wr_lane0) begin
      if (avs_address_i == OFS_B_DATA) begin
        b_data <= avs_writedata_i[7:0]; // RQ1
      end else if (avs_address_i == OFS_B_DIR) begin
        b_dir <= avs_writedata_i[7:0]; // RQ1
      end else if (avs_address_i == OFS_B_PULL) begin
        b_pull <= avs_writedata_i[7:0]; // RQ1
      end else if (avs_address_i == OFS_B_WAKE_EN) begin
        b_wake_en <= avs_writedata_i[7:0]; // RQ3
      end
    end
  end

  // Reset mode bit; stop bit is a write-only command and reads back as state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= RST_CTRL;
    end else if (ce_i) begin
      ctrl[CTRL_STOP] <= (next_pwr_state == DPIO_STOP);
      if (wr_go && avs_byteenable_i[0] && avs_address_i == OFS_CTRL) begin
        ctrl[CTRL_RST_MODE] <= avs_writedata_i[CTRL_RST_MODE]; // RQ9
      end
    end
  end

  // Sticky edge flags; a new edge wins over a write-one clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= RST_IRQ;
    end else if (ce_i) begin
      if (wr_go && avs_byteenable_i[0] && avs_address_i == OFS_IRQ_STAT) begin
        irq_stat <= irq_stat & ~avs_writedata_i[1:0] | irq_set; // RQ4 RQ5
      end else begin
        irq_stat <= irq_stat | irq_set; // RQ4 RQ5
      end
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask <= RST_IRQ;
    end else if (ce_i && wr_go && avs_byteenable_i[0] && avs_address_i == OFS_IRQ_MASK) begin
      irq_mask <= avs_writedata_i[1:0];
    end
  end

  // Level interrupt while any unmasked flag is set
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Sticky wake cause per port, write one to clear, set wins
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_stat <= RST_IRQ;
    end else if (ce_i) begin
      if (wr_go && avs_byteenable_i[0] && avs_address_i == OFS_WAKE_STAT) begin
        wake_stat <= wake_stat & ~avs_writedata_i[1:0] | wake_set; // RQ2 RQ3
      end else begin
        wake_stat <= wake_stat | wake_set; // RQ2 RQ3
      end
    end
  end

  // Power sequencer: stop, then toggle, then fixed resume delay
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      DPIO_RUN: begin
        if (stop_req) begin
          next_pwr_state = DPIO_STOP;
        end
      end
      DPIO_STOP: begin
        if (any_wake) begin
          next_pwr_state = DPIO_WAKE; // RQ2 RQ3
        end
      end
      DPIO_WAKE: begin
        if (wake_cnt == WAKE_CNT_W'(FAST_WAKE_CYC - 1)) begin
          next_pwr_state = DPIO_RUN; // RQ8
        end
      end
      default: begin
        next_pwr_state = DPIO_RUN;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_state <= DPIO_RUN;
    end else if (ce_i) begin
      pwr_state <= next_pwr_state;
    end
  end

  // Resume delay counter, cleared outside the wake state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_cnt <= '0;
    end else if (ce_i) begin
      if (pwr_state == DPIO_WAKE) begin
        wake_cnt <= wake_cnt + 1'b1; // RQ8
      end else begin
        wake_cnt <= '0;
      end
    end
  end

  // Stopped holds from the stop command until the full delay has run
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sys_stopped_o <= 1'b0;
    end else if (ce_i) begin
      sys_stopped_o <= (next_pwr_state != DPIO_RUN); // RQ8
    end
  end

  // Wake pulses for one cycle on the resume edge
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_o <= 1'b0;
    end else if (ce_i) begin
      wake_o <= (pwr_state == DPIO_WAKE) && (next_pwr_state == DPIO_RUN); // RQ8
    end
  end
endmodule
